// ==== hw/p2sel_pkg.sv ====
// Package: register map, field positions and reset values of the port 2 function select block
package p2sel_pkg;
    localparam int unsigned PIN_COUNT = 8;
    // Register byte offsets on the Wishbone slave
    localparam logic [7:0] OFS_PORT_CONFIG  = 8'h00;
    localparam logic [7:0] OFS_DIRECTION    = 8'h04;
    localparam logic [7:0] OFS_LATCH        = 8'h08;
    localparam logic [7:0] OFS_CHANNEL      = 8'h0c;
    localparam logic [7:0] OFS_CMP0_CTRL    = 8'h10;
    localparam logic [7:0] OFS_CMP1_CTRL    = 8'h14;
    localparam logic [7:0] OFS_CMP2_CTRL    = 8'h18;
    localparam logic [7:0] OFS_AMP_CTRL     = 8'h1c;
    localparam logic [7:0] OFS_PIN_LEVEL    = 8'h20;
    localparam logic [7:0] OFS_FUNC_STATUS  = 8'h24;
    // Field positions
    localparam int unsigned BIT_CMP_ENABLE  = 7;
    localparam int unsigned BIT_MODE_HI     = 4;
    localparam int unsigned BIT_MODE_LO     = 3;
    localparam int unsigned BIT_AMP_ENABLE  = 7;
    localparam int unsigned BIT_GAIN_ENABLE = 6;
    localparam int unsigned CHAN_WIDTH      = 3;
    // Pin positions with shared analog functions
    localparam int unsigned PIN_CMP2_POS    = 3;
    localparam int unsigned PIN_CMP0_POS    = 4;
    localparam int unsigned PIN_CMP1_POS    = 5;
    localparam int unsigned PIN_COMMON      = 6;
    localparam int unsigned PIN_GAIN_IN     = 1;
    // Reset values: all pins analog, all directions input
    localparam logic [7:0] RST_PORT_CONFIG  = 8'hff;
    localparam logic [7:0] RST_DIRECTION    = 8'hff;
    localparam logic [7:0] RST_LATCH        = 8'h00;
    localparam logic [7:0] RST_CHANNEL      = 8'h00;
    localparam logic [7:0] RST_CTRL         = 8'h00;
    // Input synchroniser depth
    localparam int unsigned SYNC_STAGES     = 3;
endpackage : p2sel_pkg

// ==== hw/p2sel_pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter on the last two stages
`timescale 1ns/1ns
`default_nettype none
module p2sel_pin_sync (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] pin_i,
    output logic      [7:0] level_o
);
    logic [7:0] s1_q;
    logic [7:0] s2_q;
    logic [7:0] s3_q;
    logic [7:0] lvl_q;

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_bit
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    s1_q[g]  <= 1'b0;
                    s2_q[g]  <= 1'b0;
                    s3_q[g]  <= 1'b0;
                    lvl_q[g] <= 1'b0;
                end else begin
                    s1_q[g] <= pin_i[g];
                    s2_q[g] <= s1_q[g];
                    s3_q[g] <= s2_q[g];
                    // Only a level seen on two stages counts, filtering a one-cycle glitch
                    if (s2_q[g] == s3_q[g]) begin
                        lvl_q[g] <= s3_q[g];
                    end
                end
            end
        end
    endgenerate

    assign level_o = lvl_q;
endmodule : p2sel_pin_sync
`default_nettype wire

// ==== hw/p2sel_top.sv ====
// Port 2 analog/digital function select with Wishbone register slave
//
// The Wishbone interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module p2sel_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    // Pins
    input  wire logic [7:0]  pin_i,
    output logic      [7:0]  pin_o,
    output logic      [7:0]  pin_oe_o,
    output logic      [7:0]  pin_ie_o,
    // Analog routing
    output logic      [7:0]  analog_sel_o,
    output logic      [7:0]  conv_route_o,
    output logic      [2:0]  cmp_pos_en_o,
    output logic             cmp_common_en_o,
    output logic             amp_en_o,
    output logic             gain_amp_en_o,
    output logic             amp_route_o,
    output logic             gain_route_o
);
    logic [7:0] analog_digital_port_config_q;
    logic [7:0] port2_direction_q;
    logic [7:0] port2_latch_q;
    logic [7:0] converter_channel_select_q;
    logic [7:0] comparator_control_q [3];
    logic [7:0] amplifier_control_q;
    logic [7:0] pin_level;
    logic [7:0] func_status;
    logic [7:0] analog_d;
    logic [7:0] conv_d;
    logic [7:0] oe_d;
    logic [7:0] ie_d;
    logic [2:0] cmp_pos_d;
    logic       common_d;
    logic [31:0] rdata_d;
    logic        hit_d;
    logic        req;
    logic        wr_en;
    logic [7:0]  wbyte;

    p2sel_pin_sync u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (pin_i),
        .level_o (pin_level)
    );

    // Bus handshake: ack one cycle after request, dropped the next cycle
    assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    // Write lands at the edge where the master samples ack, while its request still stands
    assign wr_en = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
    assign wbyte = wb_dat_i[7:0];

    always_comb begin
        hit_d   = 1'b1;
        rdata_d = 32'h0000_0000;
        if (wb_adr_i == p2sel_pkg::OFS_PORT_CONFIG) begin
            rdata_d[7:0] = analog_digital_port_config_q;
        end else if (wb_adr_i == p2sel_pkg::OFS_DIRECTION) begin
            rdata_d[7:0] = port2_direction_q;
        end else if (wb_adr_i == p2sel_pkg::OFS_LATCH) begin
            // Digital inputs return the pin level, others the latch
            rdata_d[7:0] = (ie_d & pin_level) | (~ie_d & port2_latch_q);
        end else if (wb_adr_i == p2sel_pkg::OFS_CHANNEL) begin
            rdata_d[7:0] = converter_channel_select_q;
        end else if (wb_adr_i == p2sel_pkg::OFS_CMP0_CTRL) begin
            rdata_d[7:0] = comparator_control_q[0];
        end else if (wb_adr_i == p2sel_pkg::OFS_CMP1_CTRL) begin
            rdata_d[7:0] = comparator_control_q[1];
        end else if (wb_adr_i == p2sel_pkg::OFS_CMP2_CTRL) begin
            rdata_d[7:0] = comparator_control_q[2];
        end else if (wb_adr_i == p2sel_pkg::OFS_AMP_CTRL) begin
            rdata_d[7:0] = amplifier_control_q;
        end else if (wb_adr_i == p2sel_pkg::OFS_PIN_LEVEL) begin
            rdata_d[7:0] = pin_level;
        end else if (wb_adr_i == p2sel_pkg::OFS_FUNC_STATUS) begin
            rdata_d[7:0] = func_status;
        end else begin
            hit_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req && hit_d;
            wb_err_o <= req && !hit_d;
            wb_dat_o <= (req && hit_d && !wb_we_i) ? rdata_d : 32'h0000_0000;
        end
    end

    // Configuration registers; reset leaves every pin analog input
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            analog_digital_port_config_q <= p2sel_pkg::RST_PORT_CONFIG;
            port2_direction_q            <= p2sel_pkg::RST_DIRECTION;
            port2_latch_q                <= p2sel_pkg::RST_LATCH;
            converter_channel_select_q   <= p2sel_pkg::RST_CHANNEL;
            amplifier_control_q          <= p2sel_pkg::RST_CTRL;
        end else if (wr_en) begin
            if (wb_adr_i == p2sel_pkg::OFS_PORT_CONFIG) begin
                analog_digital_port_config_q <= wbyte;
            end else if (wb_adr_i == p2sel_pkg::OFS_DIRECTION) begin
                port2_direction_q <= wbyte;
            end else if (wb_adr_i == p2sel_pkg::OFS_LATCH) begin
                port2_latch_q <= wbyte;
            end else if (wb_adr_i == p2sel_pkg::OFS_CHANNEL) begin
                // Only the channel number is stored
                converter_channel_select_q <= {5'h00, wbyte[p2sel_pkg::CHAN_WIDTH-1:0]};
            end else if (wb_adr_i == p2sel_pkg::OFS_AMP_CTRL) begin
                // Only the two enable bits exist
                amplifier_control_q <= wbyte & 8'hc0;
            end
        end
    end

    genvar m;
    generate
        for (m = 0; m < 3; m++) begin : g_cmp
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    comparator_control_q[m] <= p2sel_pkg::RST_CTRL;
                end else if (wr_en && wb_adr_i == p2sel_pkg::OFS_CMP0_CTRL + 8'(4 * m)) begin
                    comparator_control_q[m] <= wbyte & 8'h98;
                end
            end
        end
    endgenerate

    // Per-pin function decode
    genvar n;
    generate
        for (n = 0; n < 8; n++) begin : g_pin
            logic chan_hit;
            assign chan_hit = (converter_channel_select_q[2:0] == 3'(n));
            always_comb begin
                analog_d[n] = analog_digital_port_config_q[n];
                conv_d[n]   = analog_digital_port_config_q[n] && chan_hit;
                // A digital pin picked as channel is not driven; software keeps clear of it
                ie_d[n]     = !analog_digital_port_config_q[n] && !chan_hit
                              && port2_direction_q[n];
                // Analog pins never drive, even if software sets output direction
                oe_d[n]     = !analog_digital_port_config_q[n] && !chan_hit
                              && !port2_direction_q[n];
            end
        end
    endgenerate

    always_comb begin
        cmp_pos_d[2] = analog_digital_port_config_q[p2sel_pkg::PIN_CMP2_POS]
                       && comparator_control_q[2][p2sel_pkg::BIT_CMP_ENABLE];
        cmp_pos_d[0] = analog_digital_port_config_q[p2sel_pkg::PIN_CMP0_POS]
                       && comparator_control_q[0][p2sel_pkg::BIT_CMP_ENABLE];
        cmp_pos_d[1] = analog_digital_port_config_q[p2sel_pkg::PIN_CMP1_POS]
                       && comparator_control_q[1][p2sel_pkg::BIT_CMP_ENABLE];
        // Any comparator in common mode claims pin 6 while pin 6 is analog
        common_d = 1'b0;
        for (int k = 0; k < 3; k++) begin
            if (comparator_control_q[k][p2sel_pkg::BIT_MODE_HI]
                && comparator_control_q[k][p2sel_pkg::BIT_MODE_LO]) begin
                common_d = analog_digital_port_config_q[p2sel_pkg::PIN_COMMON];
            end
        end
    end

    assign func_status = {common_d, cmp_pos_d, oe_d[3:0] | ie_d[3:0]};

    // All pin-side outputs registered; one cycle behind the registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_o           <= 8'h00;
            pin_oe_o        <= 8'h00;
            pin_ie_o        <= 8'h00;
            analog_sel_o    <= 8'hff;
            conv_route_o    <= 8'h00;
            cmp_pos_en_o    <= 3'h0;
            cmp_common_en_o <= 1'b0;
            amp_en_o        <= 1'b0;
            gain_amp_en_o   <= 1'b0;
            amp_route_o     <= 1'b0;
            gain_route_o    <= 1'b0;
        end else begin
            pin_o           <= port2_latch_q & oe_d;
            pin_oe_o        <= oe_d;
            pin_ie_o        <= ie_d;
            analog_sel_o    <= analog_d;
            conv_route_o    <= conv_d;
            cmp_pos_en_o    <= cmp_pos_d;
            cmp_common_en_o <= common_d;
            amp_en_o        <= amplifier_control_q[p2sel_pkg::BIT_AMP_ENABLE];
            gain_amp_en_o   <= amplifier_control_q[p2sel_pkg::BIT_GAIN_ENABLE];
            // Amplifier functions only on analog-configured shared pins
            amp_route_o     <= amplifier_control_q[p2sel_pkg::BIT_AMP_ENABLE]
                               && analog_digital_port_config_q[0]
                               && analog_digital_port_config_q[2];
            gain_route_o    <= amplifier_control_q[p2sel_pkg::BIT_GAIN_ENABLE]
                               && analog_digital_port_config_q[p2sel_pkg::PIN_GAIN_IN];
        end
    end

    // Assertions
    AST_RESET_ANALOG: assert property (@(posedge clk_i)
        $past(rst_i) |-> analog_sel_o == 8'hff && pin_oe_o == 8'h00)
        else $error("Port not analog after reset");
    AST_ANALOG_FOLLOWS_CFG: assert property (@(posedge clk_i) disable iff (rst_i)
        $stable(analog_digital_port_config_q) |=> analog_sel_o == $past(analog_digital_port_config_q))
        else $error("Analog select does not follow config");
    AST_DIR_SPLIT: assert property (@(posedge clk_i) disable iff (rst_i)
        (pin_oe_o & pin_ie_o) == 8'h00 && (pin_oe_o & analog_sel_o) == 8'h00)
        else $error("Pin both driven and read or analog");
    AST_OE_FROM_DIR: assert property (@(posedge clk_i) disable iff (rst_i)
        !analog_digital_port_config_q[7] && !port2_direction_q[7] && converter_channel_select_q[2:0] != 3'h7
        |=> pin_oe_o[7])
        else $error("Digital output pin 7 not driven");
    AST_CONV_ONLY_SEL: assert property (@(posedge clk_i) disable iff (rst_i)
        $onehot0(conv_route_o) && (conv_route_o & ~analog_sel_o) == 8'h00)
        else $error("Conversion route not single analog pin");
    AST_CMP0: assert property (@(posedge clk_i) disable iff (rst_i)
        comparator_control_q[0][7] && analog_digital_port_config_q[4] |=> cmp_pos_en_o[0])
        else $error("Comparator 0 input not routed");
    AST_COMMON: assert property (@(posedge clk_i) disable iff (rst_i)
        cmp_common_en_o |-> $past(analog_digital_port_config_q[6]) && analog_sel_o[6])
        else $error("Common input on non-analog pin");
    AST_AMP_BITS: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 amp_en_o == $past(amplifier_control_q[7]) && gain_amp_en_o == $past(amplifier_control_q[6]))
        else $error("Amplifier enables wrong");
    AST_DRIVE_LATCH: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 (pin_o & pin_oe_o) == ($past(port2_latch_q) & pin_oe_o))
        else $error("Output pin not from latch");
    AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
        else $error("Ack held two cycles");
    // Bus answer checks
    AST_ERR_ONE: assert property (@(posedge clk_i) disable iff (rst_i) wb_err_o |=> !wb_err_o)
        else $error("Error held two cycles");
    AST_ACK_ERR_EXCL: assert property (@(posedge clk_i) disable iff (rst_i) !(wb_ack_o && wb_err_o))
        else $error("Ack and error together");
    AST_DAT_ONLY_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("Read data outside ack");
    AST_WRITE_AT_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == p2sel_pkg::OFS_DIRECTION
        |=> port2_direction_q == $past(wb_dat_i[7:0]))
        else $error("Direction write not taken at ack");
    // Pin routing checks
    AST_IE_FROM_DIR: assert property (@(posedge clk_i) disable iff (rst_i)
        !analog_digital_port_config_q[7] && port2_direction_q[7] && converter_channel_select_q[2:0] != 3'h7
        |=> pin_ie_o[7])
        else $error("Digital input pin 7 not read");
    AST_ANALOG_NO_DIGITAL: assert property (@(posedge clk_i) disable iff (rst_i)
        (analog_sel_o & (pin_oe_o | pin_ie_o)) == 8'h00)
        else $error("Analog pin used digitally");
    AST_CHAN_NOT_DIGITAL: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 (((pin_oe_o | pin_ie_o) & (8'h01 << $past(converter_channel_select_q[2:0]))) == 8'h00))
        else $error("Selected channel pin used digitally");
    AST_CMP1: assert property (@(posedge clk_i) disable iff (rst_i)
        comparator_control_q[1][7] && analog_digital_port_config_q[5] |=> cmp_pos_en_o[1])
        else $error("Comparator 1 input not routed");
    AST_CMP2: assert property (@(posedge clk_i) disable iff (rst_i)
        comparator_control_q[2][7] && analog_digital_port_config_q[3] |=> cmp_pos_en_o[2])
        else $error("Comparator 2 input not routed");
    AST_CMP_NEEDS_ANALOG: assert property (@(posedge clk_i) disable iff (rst_i)
        (cmp_pos_en_o & ~{analog_sel_o[3], analog_sel_o[5], analog_sel_o[4]}) == 3'h0)
        else $error("Comparator fed from digital pin");
    AST_COMMON_MODE: assert property (@(posedge clk_i) disable iff (rst_i)
        comparator_control_q[0][4] && comparator_control_q[0][3] && analog_digital_port_config_q[6]
        |=> cmp_common_en_o)
        else $error("Common input not connected");
    AST_COMMON_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
        !(comparator_control_q[0][4] && comparator_control_q[0][3])
        && !(comparator_control_q[1][4] && comparator_control_q[1][3])
        && !(comparator_control_q[2][4] && comparator_control_q[2][3]) |=> !cmp_common_en_o)
        else $error("Common input without common mode");
    AST_AMP_ROUTE: assert property (@(posedge clk_i) disable iff (rst_i)
        amp_route_o |-> amp_en_o && analog_sel_o[0] && analog_sel_o[2])
        else $error("Amplifier routed to digital pin");
    AST_GAIN_ROUTE: assert property (@(posedge clk_i) disable iff (rst_i)
        gain_route_o |-> gain_amp_en_o && analog_sel_o[1])
        else $error("Gain amplifier routed to digital pin");

    COV_DIG_OUT: cover property (@(posedge clk_i) pin_oe_o != 8'h00);
    COV_CONV: cover property (@(posedge clk_i) conv_route_o != 8'h00 && cmp_pos_en_o != 3'h0);
    COV_COMMON: cover property (@(posedge clk_i) cmp_common_en_o);
    COV_ERR: cover property (@(posedge clk_i) wb_err_o);
endmodule : p2sel_top
`default_nettype wire

// ==== verification/p2sel_pin_model.sv ====
// Partner model: external pin wiring that loops driven pins back and supplies levels elsewhere
`timescale 1ns/1ns
`default_nettype none
module p2sel_pin_model (
    input  wire logic [7:0] pin_o_i,
    input  wire logic [7:0] pin_oe_i,
    input  wire logic [7:0] ext_i,
    output logic      [7:0] level_o
);
    // Driven pins show the device value, others the board level; no pin floats
    assign level_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext_i);
endmodule // p2sel_pin_model
`default_nettype wire

// ==== verification/tb_top.sv ====
// Testbench: random and corner register traffic against the port 2 function select block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic        clk_i, rst_i, cyc, stb, we, ack, err, e, com, amp_en, gain_en, amp_rt, gain_rt, cm;
    logic [7:0]  adr, ext, pin_i, pin_o, pin_oe, pin_ie, asel, conv, cfg, dir, lat, amp, ie, oe;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, q;
    logic [2:0]  cmp_pos, ch;
    logic [7:0]  cc [3];
    int          error_cnt, n_checks, seed;

    p2sel_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .wb_err_o(err), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe), .pin_ie_o(pin_ie),
        .analog_sel_o(asel), .conv_route_o(conv), .cmp_pos_en_o(cmp_pos), .cmp_common_en_o(com),
        .amp_en_o(amp_en), .gain_amp_en_o(gain_en), .amp_route_o(amp_rt), .gain_route_o(gain_rt));
    p2sel_pin_model pins (.pin_o_i(pin_o), .pin_oe_i(pin_oe), .ext_i(ext), .level_o(pin_i));

    initial begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        n_checks++;
        if (g !== x) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, x, g);
        end
    endtask

    // Classic single cycle; no fixed latency assumed, only a bounded wait
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
        int n;
        @(posedge clk_i);
        cyc <= 1'h1; stb <= 1'h1; we <= w; adr <= a; wdat <= {24'h000000, d}; sel <= s;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'h1 && err !== 1'h1 && n < 20);
        q = rdat;
        e = err;
        if (n >= 20) begin
            error_cnt++;
            $display("BAD wb_answer expected 1 seen 0");
            tally_and_finish;
        end
        cyc <= 1'h0; stb <= 1'h0; we <= 1'h0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] x, input string nm);
        wb(1'h0, a, 8'h00, 4'hf);
        chk(nm, {24'h000000, x}, q);
    endtask

    task automatic wr_all;
        wb(1'h1, 8'h00, cfg, 4'h1);
        wb(1'h1, 8'h04, dir, 4'h1);
        wb(1'h1, 8'h08, lat, 4'h1);
        wb(1'h1, 8'h0c, {5'h00, ch}, 4'h1);
        for (int k = 0; k < 3; k++) wb(1'h1, 8'h10 + 8'(4 * k), cc[k], 4'h1);
        wb(1'h1, 8'h1c, amp, 4'h1);
        repeat (8) @(posedge clk_i);
    endtask

    // Expected routing worked out from the shadow copy of the registers
    task automatic check_outs;
        logic [7:0] s;
        s  = 8'h01 << ch;
        oe = ~cfg & ~dir & ~s;
        ie = ~cfg & dir & ~s;
        cm = cfg[6] & ((cc[0][4] & cc[0][3]) | (cc[1][4] & cc[1][3]) | (cc[2][4] & cc[2][3]));
        chk("analog_sel", {24'h0, cfg}, {24'h0, asel});
        chk("conv_route", {24'h0, cfg & s}, {24'h0, conv});
        chk("pin_oe", {24'h0, oe}, {24'h0, pin_oe});
        chk("pin_ie", {24'h0, ie}, {24'h0, pin_ie});
        chk("pin_o", {24'h0, lat & oe}, {24'h0, pin_o});
        chk("cmp_pos", {29'h0, cc[2][7] & cfg[3], cc[1][7] & cfg[5], cc[0][7] & cfg[4]}, {29'h0, cmp_pos});
        chk("common", {31'h0, cm}, {31'h0, com});
        chk("amp", {28'h0, amp[7], amp[6], amp[7] & cfg[0] & cfg[2], amp[6] & cfg[1]},
            {28'h0, amp_en, gain_en, amp_rt, gain_rt});
    endtask

    task automatic reset_and_check;
        rst_i <= 1'h1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'h0;
        cfg = 8'hff; dir = 8'hff; lat = 8'h00; ch = 3'h0; amp = 8'h00;
        for (int k = 0; k < 3; k++) cc[k] = 8'h00;
        @(posedge clk_i);
        chk("rst_sel", 32'h000000ff, {24'h0, asel});
        chk("rst_pins", 32'h0, {8'h0, pin_oe, pin_ie, pin_o});
        chk("rst_cmp", 32'h0, {24'h0, cmp_pos, com, amp_en, gain_en, amp_rt, gain_rt});
        rd_chk(8'h00, 8'hff, "rst_cfg");
        rd_chk(8'h04, 8'hff, "rst_dir");
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        #100000;
        error_cnt++;
        tally_and_finish;
    end

    initial begin
        rst_i = 1'h1; cyc = 1'h0; stb = 1'h0; we = 1'h0; adr = 8'h00; wdat = 32'h0; sel = 4'h0;
        ext = 8'h00; seed = 33352; error_cnt = 0; n_checks = 0;
        reset_and_check;
        for (int i = 0; i < 40; i++) begin
            cfg = $random(seed);
            ch  = $random(seed);
            if (i == 0) cfg = 8'h00;
            if (i == 1) cfg = 8'hff;
            if (i == 0) ch = 3'h7;
            cfg[ch] = 1'h1; // Channel only on an analog pin
            dir = $random(seed) | cfg; // Analog pins kept at input
            lat = $random(seed);
            amp = $random(seed);
            for (int k = 0; k < 3; k++) cc[k] = (i == 1) ? 8'h98 : 8'($random(seed));
            ext <= $random(seed);
            wr_all;
            check_outs;
            rd_chk(8'h08, (ie & ext) | (~ie & lat), "latch_rd");
            rd_chk(8'h20, (oe & lat) | (~oe & ext), "level_rd");
            rd_chk(8'h24, {cm, cc[2][7] & cfg[3], cc[1][7] & cfg[5], cc[0][7] & cfg[4], oe[3:0] | ie[3:0]},
                "status_rd");
            rd_chk(8'h18, cc[2] & 8'h98, "cmp2_rd");
            rd_chk(8'h1c, amp & 8'hc0, "amp_rd");
        end
        wb(1'h1, 8'h00, ~cfg, 4'h0);
        rd_chk(8'h00, cfg, "sel_off");
        wb(1'h1, 8'h40, 8'h00, 4'h1);
        chk("unmapped_err", 32'h1, {31'h0, e});
        reset_and_check;
        tally_and_finish;
    end
endmodule // tb_top
`default_nettype wire
